// ### logic/cpu_register_set.sv
// CPU register set with operand formatting behind an AHB-Lite slave
module cpu_register_set
    import cpu_regs_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    output logic irq,
    output logic addr_error_req,
    output logic [31:0] table_fetch_addr
);

    logic [31:0] gpr [16];
    logic [31:0] processor_state;
    logic [31:0] global_base;
    logic [31:0] vector_base;
    logic [31:0] mult_accum_high;
    logic [31:0] mult_accum_low;
    logic [31:0] return_address;
    logic [31:0] program_counter;
    logic [31:0] vec_stack_entry;
    logic [31:0] vec_prog_entry;
    logic [31:0] acc_ctrl;
    logic [31:0] acc_addr;
    logic [31:0] acc_data;
    logic [31:0] imm_ctrl;
    logic [31:0] imm_result;
    logic [NUM_EV-1:0] irq_stat;
    logic [NUM_EV-1:0] irq_mask;
    logic boot_load;

    // Registered address phase
    logic dp_valid;
    logic dp_write;
    logic [7:0] dp_addr;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dp_valid <= 1'b0;
            dp_write <= 1'b0;
            dp_addr <= 8'h00;
        end else if (hready) begin
            dp_valid <= hsel && htrans[1];
            dp_write <= hwrite;
            dp_addr <= haddr[7:0];
        end
    end

    logic wr;
    assign wr = dp_valid && dp_write;

    // Access request decode
    logic acc_go;
    logic [1:0] acc_size;
    logic acc_stack;
    logic [3:0] acc_reg;
    logic misaligned;
    logic [31:0] load_val;
    assign acc_go = wr && dp_addr == OFF_ACC_CTRL && hwdata[AC_GO];
    assign acc_size = hwdata[AC_SIZE_LSB +: 2];
    assign acc_stack = hwdata[AC_STACK];
    assign acc_reg = hwdata[AC_REG_LSB +: 4];

    // Stack traffic must be long words at 4n, others align to size
    always_comb begin
        misaligned = 1'b0;
        if (acc_stack) begin
            misaligned = acc_size != SZ_LONG
                || gpr[STACK_REG][1:0] != 2'b00;
        end else if (acc_size == SZ_WORD) begin
            misaligned = acc_addr[0];
        end else if (acc_size == SZ_LONG) begin
            misaligned = acc_addr[1:0] != 2'b00;
        end
    end

    // Sign extension of loaded memory data
    always_comb begin
        case (acc_size)
            SZ_BYTE: load_val = {{24{acc_data[7]}}, acc_data[7:0]};
            SZ_WORD: begin
                load_val = {{16{acc_data[15]}}, acc_data[15:0]};
            end
            default: load_val = acc_data;
        endcase
    end

    // Immediate formatter
    logic imm_go;
    logic [2:0] imm_op;
    logic [3:0] imm_dst;
    logic [31:0] imm_ext;
    logic [31:0] imm_val;
    logic imm_wb;
    assign imm_go = wr && dp_addr == OFF_IMM_CTRL;
    assign imm_op = hwdata[10:8];
    assign imm_dst = hwdata[15:12];

    always_comb begin
        imm_wb = 1'b1;
        if (imm_op == OP_MOVE || imm_op == OP_ADD || imm_op == OP_CMPEQ) begin
            imm_ext = {{24{hwdata[7]}}, hwdata[7:0]};
        end else begin
            imm_ext = {24'h00_0000, hwdata[7:0]};
        end
        // Compare and test against the index register only
        case (imm_op)
            OP_MOVE: imm_val = imm_ext;
            OP_ADD: imm_val = gpr[imm_dst] + imm_ext;
            OP_AND: imm_val = gpr[INDEX_REG] & imm_ext;
            OP_OR: imm_val = gpr[INDEX_REG] | imm_ext;
            OP_XOR: imm_val = gpr[INDEX_REG] ^ imm_ext;
            OP_CMPEQ: begin
                imm_val = {31'h0, gpr[INDEX_REG] == imm_ext};
                imm_wb = 1'b0;
            end
            OP_TEST: begin
                imm_val = {31'h0, (gpr[INDEX_REG] & imm_ext) == 32'h0};
                imm_wb = 1'b0;
            end
            default: begin
                imm_val = 32'h0000_0000;
                imm_wb = 1'b0;
            end
        endcase
    end

    logic [3:0] imm_target;
    assign imm_target = (imm_op == OP_MOVE || imm_op == OP_ADD)
        ? imm_dst : INDEX_REG;

    // General registers: no reset, except the stack pointer from the table
    genvar g;
    generate
        for (g = 0; g < 16; g++) begin : gen_gpr
            always_ff @(posedge hclk) begin
                if (g == 15 && boot_load) begin
                    gpr[g] <= vec_stack_entry;
                end else if (acc_go && !misaligned && !acc_stack
                        && acc_reg == g) begin
                    gpr[g] <= load_val;
                end else if (acc_go && !misaligned && acc_stack
                        && g == 15) begin
                    gpr[g] <= gpr[g] + 32'h0000_0004; // pop one long
                end else if (imm_go && imm_wb && imm_target == g) begin
                    gpr[g] <= imm_val;
                end else if (wr && dp_addr == OFF_GPR_BASE + 8'(g * 4)) begin
                    gpr[g] <= hwdata;
                end
            end
        end
    endgenerate

    // One-shot load of stack pointer and program counter after reset
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            boot_load <= 1'b1;
        end else begin
            boot_load <= 1'b0;
        end
    end

    // Vector table entries are writable so software can model the table
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            vec_stack_entry <= VEC_STACK_RESET;
            vec_prog_entry <= VEC_PROG_RESET;
        end else if (wr && dp_addr == OFF_VEC_STACK) begin
            vec_stack_entry <= hwdata;
        end else if (wr && dp_addr == OFF_VEC_PROG) begin
            vec_prog_entry <= hwdata;
        end
    end

    // Processor state: mask bits set, reserved bits zero at reset
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            processor_state <= PS_RESET;
        end else if (wr && dp_addr == OFF_PSTATE) begin
            processor_state <= hwdata & PS_USED;
        end else if (imm_go && (imm_op == OP_CMPEQ || imm_op == OP_TEST)) begin
            processor_state[TBIT] <= imm_val[0];
        end
    end

    // Vector base has a defined reset, like the processor state and the interrupt mask
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            vector_base <= VBASE_RESET;
        end else if (wr && dp_addr == OFF_VBASE) begin
            vector_base <= hwdata;
        end
    end

    // Undefined-at-reset registers, software writes and the immediate result
    always_ff @(posedge hclk) begin
        if (wr && dp_addr == OFF_GBASE) global_base <= hwdata;
        if (wr && dp_addr == OFF_MAC_HI) mult_accum_high <= hwdata;
        if (wr && dp_addr == OFF_MAC_LO) mult_accum_low <= hwdata;
        if (wr && dp_addr == OFF_RADDR) return_address <= hwdata;
        if (wr && dp_addr == OFF_ACC_ADDR) acc_addr <= hwdata;
        if (wr && dp_addr == OFF_ACC_DATA) acc_data <= hwdata;
        if (imm_go) imm_result <= imm_val;
        if (imm_go) imm_ctrl <= hwdata;
        if (acc_go) acc_ctrl <= hwdata;
    end

    // Program counter loads from the vector table after reset
    always_ff @(posedge hclk) begin
        if (boot_load) begin
            program_counter <= vec_prog_entry;
        end else if (wr && dp_addr == OFF_PROG_CNT) begin
            program_counter <= hwdata;
        end
    end

    // Exception request and the counter-relative table fetch address
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            addr_error_req <= 1'b0;
            table_fetch_addr <= 32'h0000_0000;
        end else begin
            addr_error_req <= acc_go && misaligned;
            // Long table entries sit at 4n past the program counter with bits 1:0 cleared
            table_fetch_addr <= {program_counter[31:2], 2'b00}
                + {22'h0, acc_addr[7:0], 2'b00};
        end
    end

    // Sticky events; a new event beats a write-one clear
    logic [NUM_EV-1:0] ev;
    assign ev[EV_ADDR_ERR] = acc_go && misaligned && !acc_stack;
    assign ev[EV_LOAD_DONE] = acc_go && !misaligned;
    assign ev[EV_STACK_ERR] = acc_go && misaligned && acc_stack;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_stat <= '0;
            irq_mask <= '0;
            irq <= 1'b0;
        end else begin
            if (wr && dp_addr == OFF_IRQ_STAT) begin
                irq_stat <= (irq_stat & ~hwdata[NUM_EV-1:0]) | ev;
            end else begin
                irq_stat <= irq_stat | ev;
            end
            if (wr && dp_addr == OFF_IRQ_MASK) begin
                irq_mask <= hwdata[NUM_EV-1:0];
            end
            // Level follows the stored state one cycle late
            irq <= |(irq_stat & irq_mask);
        end
    end

    // Read mux; registered so the answer is one cycle late
    logic [31:0] rd;
    always_comb begin
        rd = 32'h0000_0000;
        if (dp_addr < OFF_PSTATE) begin
            rd = gpr[dp_addr[5:2]];
        end else begin
            case (dp_addr)
                OFF_PSTATE: rd = processor_state;
                OFF_GBASE: rd = global_base;
                OFF_VBASE: rd = vector_base;
                OFF_MAC_HI: rd = mult_accum_high;
                OFF_MAC_LO: rd = mult_accum_low;
                OFF_RADDR: rd = return_address;
                OFF_PROG_CNT: rd = program_counter;
                OFF_IRQ_STAT: rd = {{(32-NUM_EV){1'b0}}, irq_stat};
                OFF_IRQ_MASK: rd = {{(32-NUM_EV){1'b0}}, irq_mask};
                OFF_VEC_STACK: rd = vec_stack_entry;
                OFF_VEC_PROG: rd = vec_prog_entry;
                OFF_ACC_CTRL: rd = acc_ctrl;
                OFF_ACC_ADDR: rd = acc_addr;
                OFF_ACC_DATA: rd = acc_data;
                OFF_IMM_CTRL: rd = imm_ctrl;
                OFF_IMM_RES: rd = imm_result;
                default: rd = 32'h0000_0000;
            endcase
        end
    end

    // Data phase: wait state on reads, zero-wait on writes
    logic rd_pending;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rd_pending <= 1'b0;
            hreadyout <= 1'b1;
            hrdata <= 32'h0000_0000;
        end else if (hready && hsel && htrans[1] && !hwrite) begin
            rd_pending <= 1'b1;
            hreadyout <= 1'b0;
        end else if (rd_pending) begin
            rd_pending <= 1'b0;
            hreadyout <= 1'b1;
            hrdata <= rd;
        end
    end

    // Always OKAY
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hresp <= 1'b0;
        end else begin
            hresp <= 1'b0;
        end
    end

endmodule : cpu_register_set

// ### logic/cpu_regs_pkg.sv
// Constants for the CPU register set and operand formatter
package cpu_regs_pkg;
    // Register bus byte offsets
    localparam logic [7:0] OFF_GPR_BASE = 8'h00; // 16 words, 0x00..0x3c
    localparam logic [7:0] OFF_PSTATE = 8'h40;
    localparam logic [7:0] OFF_GBASE = 8'h44;
    localparam logic [7:0] OFF_VBASE = 8'h48;
    localparam logic [7:0] OFF_MAC_HI = 8'h4c;
    localparam logic [7:0] OFF_MAC_LO = 8'h50;
    localparam logic [7:0] OFF_RADDR = 8'h54;
    localparam logic [7:0] OFF_PROG_CNT = 8'h58;
    localparam logic [7:0] OFF_IRQ_STAT = 8'h5c;
    localparam logic [7:0] OFF_IRQ_MASK = 8'h60;
    localparam logic [7:0] OFF_VEC_STACK = 8'h64;
    localparam logic [7:0] OFF_VEC_PROG = 8'h68;
    localparam logic [7:0] OFF_ACC_CTRL = 8'h6c;
    localparam logic [7:0] OFF_ACC_ADDR = 8'h70;
    localparam logic [7:0] OFF_ACC_DATA = 8'h74;
    localparam logic [7:0] OFF_IMM_CTRL = 8'h78;
    localparam logic [7:0] OFF_IMM_RES = 8'h7c;
    // Processor state layout and register reset values
    localparam int PS_MASK_LSB = 4;
    localparam logic [31:0] PS_USED = 32'h0000_03f3;
    localparam logic [31:0] PS_RESET = 32'h0000_00f0;
    localparam logic [31:0] VBASE_RESET = 32'h0000_0000;
    localparam logic [31:0] VEC_STACK_RESET = 32'h0000_0000;
    localparam logic [31:0] VEC_PROG_RESET = 32'h0000_0000;
    // Access control fields
    localparam int AC_GO = 0;
    localparam int AC_SIZE_LSB = 1; // 2 bits
    localparam int AC_STACK = 3;
    localparam int AC_REG_LSB = 4; // 4 bits
    localparam logic [1:0] SZ_BYTE = 2'h0;
    localparam logic [1:0] SZ_WORD = 2'h1;
    localparam logic [1:0] SZ_LONG = 2'h2;
    localparam logic [3:0] INDEX_REG = 4'h0;
    localparam logic [3:0] STACK_REG = 4'hf;
    // Immediate control: bits 7:0 value, 10:8 op, 15:12 dest
    localparam logic [2:0] OP_MOVE = 3'h0;
    localparam logic [2:0] OP_ADD = 3'h1;
    localparam logic [2:0] OP_CMPEQ = 3'h2;
    localparam logic [2:0] OP_TEST = 3'h3;
    localparam logic [2:0] OP_AND = 3'h4;
    localparam logic [2:0] OP_OR = 3'h5;
    localparam logic [2:0] OP_XOR = 3'h6;
    // Interrupt status bits and the processor state T bit
    localparam int EV_ADDR_ERR = 0;
    localparam int EV_LOAD_DONE = 1;
    localparam int EV_STACK_ERR = 2;
    localparam int NUM_EV = 3;
    localparam int TBIT = 0;
endpackage : cpu_regs_pkg

// ### verif/cpu_register_set_properties.sv
// Concurrent checks on the register set ports
module cpu_register_set_properties
    import cpu_regs_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic irq,
    input wire logic addr_error_req,
    input wire logic [31:0] table_fetch_addr
);
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    logic rd_take;
    logic wr_take;
    logic [2:0] since_acc;
    // Accepted address phases
    assign rd_take = hsel && hready && htrans[1] && !hwrite;
    assign wr_take = hsel && hready && htrans[1] && hwrite;
    // Cycles since the last access-control write, saturating at 7
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            since_acc <= 3'h7;
        end else if (wr_take && haddr[7:0] == OFF_ACC_CTRL) begin
            since_acc <= 3'h0;
        end else if (since_acc != 3'h7) begin
            since_acc <= since_acc + 3'h1;
        end
    end
    sequence s_rd_wait;
        !hreadyout ##1 hreadyout;
    endsequence
    property p_read_wait;
        rd_take |=> s_rd_wait;
    endproperty
    property p_write_fast;
        wr_take |=> hreadyout;
    endproperty
    property p_okay;
        hresp == 1'b0;
    endproperty
    property p_err_pulse;
        addr_error_req |=> !addr_error_req;
    endproperty
    property p_err_cause;
        addr_error_req |-> since_acc <= 3'h4;
    endproperty
    property p_tfa_align;
        table_fetch_addr[1:0] == 2'h0;
    endproperty
    property p_hrdata_hold;
        $changed(hrdata) |-> $past(rd_take) || $past(rd_take, 2);
    endproperty
    property p_release;
        $rose(hresetn) |-> hreadyout && !irq && !addr_error_req;
    endproperty
    a_read_wait: assert property (p_read_wait)
        else $error("read data phase not one wait cycle");
    a_write_fast: assert property (p_write_fast)
        else $error("write data phase stalled");
    a_okay: assert property (p_okay)
        else $error("response not okay");
    a_err_pulse: assert property (p_err_pulse)
        else $error("exception request longer than one cycle");
    a_err_cause: assert property (p_err_cause)
        else $error("exception request without an access");
    a_tfa_align: assert property (p_tfa_align)
        else $error("table fetch address not word aligned");
    a_hrdata_hold: assert property (p_hrdata_hold)
        else $error("read data changed without a read");
    a_release: assert property (p_release)
        else $error("outputs not idle after reset release");
endmodule : cpu_register_set_properties

// ### verif/exception_sink.sv
// Model of the exception logic that takes address error requests
module exception_sink (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic addr_error_req,
    output logic [7:0] taken
);
    // Each one-cycle request is one exception entry
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            taken <= 8'h00;
        end else if (addr_error_req === 1'b1) begin
            taken <= taken + 8'h01;
        end
    end
endmodule : exception_sink

// ### verif/cpu_register_set_bench.sv
// Self-checking bench for the CPU register set
module cpu_register_set_bench
    import cpu_regs_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0000_0000;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0000_0000;
    logic [31:0] hrdata;
    logic [31:0] table_fetch_addr;
    logic [31:0] q;
    logic hreadyout, hresp, irq, addr_error_req;
    logic [7:0] taken;
    int err_total = 0;
    int tests_run = 0;
    cpu_register_set cpu_register_set_i (.hclk(hclk), .hresetn(hresetn),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .irq(irq),
        .addr_error_req(addr_error_req),
        .table_fetch_addr(table_fetch_addr));
    exception_sink exception_sink_i (.hclk(hclk), .hresetn(hresetn),
        .addr_error_req(addr_error_req), .taken(taken));
    initial begin
        forever #50 hclk = ~hclk;
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask : check
    // Single word transfer; the wait in each phase is set by hready only
    task automatic xfer(input logic w, input logic [7:0] a,
                        input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= {24'h00_0000, a};
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        q = hrdata;
    endtask : xfer
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        xfer(1'b1, a, d);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        xfer(1'b0, a, 32'h0000_0000);
        check(q, exp);
    endtask : rd
    task automatic do_reset;
        hsel <= 1'b0;
        htrans <= 2'h0;
        hresetn <= 1'b0;
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
    endtask : do_reset
    task automatic t_reset;
        rd(OFF_PSTATE, PS_RESET);
        rd(OFF_VBASE, VBASE_RESET);
        rd(8'h3c, VEC_STACK_RESET);
        rd(OFF_PROG_CNT, VEC_PROG_RESET);
    endtask : t_reset
    // Every register from 0x00 to the program counter (0x58) except the processor state (PS_USED bits only) holds a full word
    task automatic t_regs;
        logic [31:0] d;
        for (int i = 0; i < 23; i++) begin
            d = 32'hc3a5_0000 | 32'(i);
            wr(8'(4 * i), d);
            rd(8'(4 * i),
                (i == 16) ? d & PS_USED : d);
        end
    endtask : t_regs
    // Memory-style load or stack step, then the register and exception count
    task automatic ld(input logic [1:0] sz, input logic [31:0] ad,
                      input logic stk, input logic [7:0] ra,
                      input logic [31:0] exp, input logic [7:0] errs);
        wr(OFF_ACC_ADDR, ad);
        wr(OFF_ACC_CTRL, {24'h00_0000, 4'h3, stk, sz, 1'b1});
        repeat (3) @(posedge hclk);
        rd(ra, exp);
        check(32'(taken), 32'(errs));
    endtask : ld
    task automatic t_loads;
        wr(8'h0c, 32'h1111_1111);
        wr(OFF_ACC_DATA, 32'h0000_8081);
        ld(SZ_BYTE, 32'h0000_0003, 0, 8'h0c, 32'hffff_ff81, 0);
        ld(SZ_WORD, 32'h0000_0002, 0, 8'h0c, 32'hffff_8081, 0);
        ld(SZ_LONG, 32'h0000_0004, 0, 8'h0c, 32'h0000_8081, 0);
        ld(SZ_WORD, 32'h0000_0001, 0, 8'h0c, 32'h0000_8081, 1);
        ld(SZ_LONG, 32'h0000_0002, 0, 8'h0c, 32'h0000_8081, 2);
        wr(8'h3c, 32'h0000_0100);
        ld(SZ_LONG, 32'h0000_0000, 1, 8'h3c, 32'h0000_0104, 2);
        ld(SZ_WORD, 32'h0000_0000, 1, 8'h3c, 32'h0000_0104, 3);
        wr(8'h3c, 32'h0000_0102);
        ld(SZ_LONG, 32'h0000_0000, 1, 8'h3c, 32'h0000_0102, 4);
        rd(OFF_IRQ_STAT, 32'h0000_0007);
    endtask : t_loads
    // Masked, unmasked, then cleared by a written one
    task automatic t_irq;
        wr(OFF_IRQ_MASK, 32'h0000_0000);
        repeat (2) @(posedge hclk);
        check(32'(irq), 32'h0000_0000);
        wr(OFF_IRQ_MASK, 32'h0000_0004);
        repeat (2) @(posedge hclk);
        check(32'(irq), 32'h0000_0001);
        wr(OFF_IRQ_STAT, 32'h0000_0004);
        repeat (2) @(posedge hclk);
        check(32'(irq), 32'h0000_0000);
        rd(OFF_IRQ_STAT, 32'h0000_0003);
    endtask : t_irq
    task automatic imm(input logic [2:0] op, input logic [3:0] dst);
        wr(OFF_IMM_CTRL, {16'h0000, dst, 1'b0, op, 8'h8f});
    endtask : imm
    task automatic tbit(input logic [31:0] exp);
        xfer(1'b0, OFF_PSTATE, 32'h0000_0000);
        check(32'(q[TBIT]), exp);
    endtask : tbit
    task automatic t_imm;
        wr(8'h00, 32'h1234_56f0);
        imm(OP_MOVE, 4'h5);
        rd(8'h14, 32'hffff_ff8f);
        imm(OP_ADD, 4'h5);
        rd(8'h14, 32'hffff_ff1e);
        imm(OP_AND, 4'h0);
        rd(8'h00, 32'h0000_0080);
        imm(OP_OR, 4'h0);
        rd(8'h00, 32'h0000_008f);
        imm(OP_XOR, 4'h0);
        rd(8'h00, 32'h0000_0000);
        wr(8'h00, 32'hffff_ff8f);
        imm(OP_CMPEQ, 4'h0);
        tbit(32'h0000_0001);
        wr(8'h00, 32'h0000_0100);
        imm(OP_CMPEQ, 4'h0);
        tbit(32'h0000_0000);
        imm(OP_TEST, 4'h0);
        tbit(32'h0000_0001);
    endtask : t_imm
    task automatic t_fetch;
        wr(OFF_PROG_CNT, 32'h0000_1006);
        wr(OFF_ACC_ADDR, 32'h0000_0005);
        repeat (2) @(posedge hclk);
        check(table_fetch_addr, 32'h0000_1018);
    endtask : t_fetch
    task automatic print_verdict;
        if (err_total == 0 && tests_run > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : print_verdict
    initial begin
        do_reset();
        t_reset();
        t_regs();
        t_loads();
        t_irq();
        t_imm();
        t_fetch();
        do_reset();
        t_reset();
        print_verdict();
    end
    // Whole run needs about 340 cycles
    initial begin
        repeat (5000) @(posedge hclk);
        err_total++;
        print_verdict();
    end
endmodule : cpu_register_set_bench
bind cpu_register_set cpu_register_set_properties
    cpu_register_set_properties_i (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .irq(irq), .addr_error_req(addr_error_req),
    .table_fetch_addr(table_fetch_addr));
